// ==== rtl/mrx_pkg.sv ====
package mrx_pkg;

    localparam int DATA_W   = 8;
    localparam int ADDR_W   = 7;
    localparam int PC_W     = 13;
    localparam int OP_W     = 3;

    localparam logic [ADDR_W-1:0] ADDR_MAX = 7'h7F;
    localparam logic [DATA_W-1:0] W_RST    = 8'h00;
    localparam logic [PC_W-1:0]   PC_RST   = 13'h0000;
    localparam logic [PC_W-1:0]   PC_STEP  = 13'h0001;
    localparam logic              DEST_W   = 1'b0;
    localparam logic              DEST_F   = 1'b1;
    localparam int                MSB      = DATA_W - 1;

    typedef enum logic [2:0] {
        OP_NOP    = 3'h0,
        OP_MOVE_FILE_OP   = 3'h1,
        OP_RETURN_FROM_IRQ_OP = 3'h2,
        OP_RLF    = 3'h3,
        OP_RRF    = 3'h4,
        OP_RETURN_WITH_LITERAL_OP  = 3'h5
    } mrx_op_e;

    typedef enum logic [0:0] {
        ST_EXEC  = 1'b0,
        ST_FLUSH = 1'b1
    } mrx_state_e;

    typedef struct packed {
        logic                valid;
        mrx_op_e             op;
        logic [ADDR_W-1:0]   fileAddr;
        logic                dest;
        logic [DATA_W-1:0]   literal;
    } mrx_instr_s;

    typedef struct packed {
        logic                wrEn;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } mrx_fwr_s;

    typedef struct packed {
        mrx_state_e          state;
        logic [DATA_W-1:0]   wReg;
        logic [PC_W-1:0]     pc;
        logic                carry;
        logic                zero;
        logic                global_irq_enable;
        logic                popStack;
        logic                busy;
        logic                done;
        mrx_fwr_s            fileWr;
    } mrx_state_s;

endpackage

// ==== rtl/mrx_exec.sv ====
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - move-file takes 7-bit address 0..127 and direction bit, copies value unchanged
// - move-file direction 0 writes working register, 1 writes file register back
// - move-file updates zero from moved value; other flags untouched
// - return-from-interrupt loads pc from stack top, sets global irq enable
// - rotate-left shifts through carry, changes only carry, address 0..127
// - rotate-left direction 0 to working register, 1 to file register
// - rotate-right shifts through carry, changes only carry; direction 0 to working
// - rotate-right direction 1 writes result back to file register
// - return-with-literal loads 8-bit literal into working register, no flags
// - return-with-literal loads pc from stack top
// - return-with-literal takes two cycles, second cycle does nothing
module mrx_exec (
    input  wire logic                         mclk,
    input  wire logic                         rst,
    input  wire mrx_pkg::mrx_instr_s          instr,
    input  wire logic [mrx_pkg::DATA_W-1:0]   fileRdData,
    input  wire logic [mrx_pkg::PC_W-1:0]     stackTop,
    output logic [mrx_pkg::ADDR_W-1:0]        fileRdAddr,
    output mrx_pkg::mrx_fwr_s                 fileWr,
    output logic                              stackPop,
    output logic [mrx_pkg::DATA_W-1:0]        wRegOut,
    output logic [mrx_pkg::PC_W-1:0]          pcOut,
    output logic                              carryFlag,
    output logic                              zeroFlag,
    output logic                              globalIrqEnable,
    output logic                              busy,
    output logic                              instrDone
);

    mrx_pkg::mrx_state_s cur_ff;
    mrx_pkg::mrx_state_s nxt_cur;
    logic [mrx_pkg::DATA_W-1:0] result;
    logic                       resCarry;

    // file read is combinational: the address leaves straight from the
    // instruction so the operand arrives in the same cycle
    assign fileRdAddr = instr.fileAddr;

    always_comb begin
        result   = fileRdData;
        resCarry = cur_ff.carry;
        case (instr.op)
            mrx_pkg::OP_RLF: begin
                result   = {fileRdData[mrx_pkg::MSB-1:0], cur_ff.carry};
                resCarry = fileRdData[mrx_pkg::MSB];
            end
            mrx_pkg::OP_RRF: begin
                result   = {cur_ff.carry, fileRdData[mrx_pkg::MSB:1]};
                resCarry = fileRdData[0];
            end
            default: begin
                result   = fileRdData;
                resCarry = cur_ff.carry;
            end
        endcase
    end

    always_comb begin
        nxt_cur             = cur_ff;
        nxt_cur.popStack    = 1'b0;
        nxt_cur.done        = 1'b0;
        nxt_cur.fileWr.wrEn = 1'b0;
        case (cur_ff.state)
            mrx_pkg::ST_FLUSH: begin
                // second cycle of a branch: no work while new pc settles
                nxt_cur.state = mrx_pkg::ST_EXEC;
                nxt_cur.busy  = 1'b0;
                nxt_cur.done  = 1'b1;
            end
            default: begin
                if (instr.valid) begin
                    nxt_cur.pc = cur_ff.pc + mrx_pkg::PC_STEP;
                    nxt_cur.done = 1'b1;
                    case (instr.op)
                        mrx_pkg::OP_MOVE_FILE_OP,
                        mrx_pkg::OP_RLF,
                        mrx_pkg::OP_RRF: begin
                            if (instr.dest == mrx_pkg::DEST_F) begin
                                nxt_cur.fileWr.wrEn = 1'b1;
                                nxt_cur.fileWr.addr = instr.fileAddr;
                                nxt_cur.fileWr.data = result;
                            end else begin
                                nxt_cur.wReg = result;
                            end
                            if (instr.op == mrx_pkg::OP_MOVE_FILE_OP) begin
                                nxt_cur.zero = (result == '0);
                            end else begin
                                nxt_cur.carry = resCarry;
                            end
                        end
                        mrx_pkg::OP_RETURN_FROM_IRQ_OP: begin
                            nxt_cur.pc       = stackTop;
                            nxt_cur.global_irq_enable      = 1'b1;
                            nxt_cur.popStack = 1'b1;
                            nxt_cur.state    = mrx_pkg::ST_FLUSH;
                            nxt_cur.busy     = 1'b1;
                            nxt_cur.done     = 1'b0;
                        end
                        mrx_pkg::OP_RETURN_WITH_LITERAL_OP: begin
                            nxt_cur.wReg     = instr.literal;
                            nxt_cur.pc       = stackTop;
                            nxt_cur.popStack = 1'b1;
                            nxt_cur.state    = mrx_pkg::ST_FLUSH;
                            nxt_cur.busy     = 1'b1;
                            nxt_cur.done     = 1'b0;
                        end
                        default: begin
                            // no-operation: only the pc step above
                            nxt_cur.done = 1'b1;
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cur_ff.state    <= mrx_pkg::ST_EXEC;
            cur_ff.wReg     <= mrx_pkg::W_RST;
            cur_ff.pc       <= mrx_pkg::PC_RST;
            cur_ff.carry    <= 1'b0;
            cur_ff.zero     <= 1'b0;
            cur_ff.global_irq_enable      <= 1'b0;
            cur_ff.popStack <= 1'b0;
            cur_ff.busy     <= 1'b0;
            cur_ff.done     <= 1'b0;
            cur_ff.fileWr   <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign fileWr          = cur_ff.fileWr;
    assign stackPop        = cur_ff.popStack;
    assign wRegOut         = cur_ff.wReg;
    assign pcOut           = cur_ff.pc;
    assign carryFlag       = cur_ff.carry;
    assign zeroFlag        = cur_ff.zero;
    assign globalIrqEnable = cur_ff.global_irq_enable;
    assign busy            = cur_ff.busy;
    assign instrDone       = cur_ff.done;

endmodule

`default_nettype wire

// ==== bench/mrx_exec_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module mrx_exec_asserts (
    input wire logic                mclk,
    input wire logic                rst,
    input wire mrx_pkg::mrx_instr_s instr,
    input wire logic [7:0]          fileRdData,
    input wire logic [12:0]         stackTop,
    input wire mrx_pkg::mrx_fwr_s   fileWr,
    input wire logic                stackPop,
    input wire logic [7:0]          wRegOut,
    input wire logic [12:0]         pcOut,
    input wire logic                carryFlag,
    input wire logic                zeroFlag,
    input wire logic                globalIrqEnable,
    input wire logic                busy,
    input wire logic                instrDone
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // busy gates acceptance, so every antecedent starts from tk
    wire logic       tk = instr.valid && !busy;
    wire logic [2:0] op = instr.op;
    a_move_zero: assert property (
        tk && op == 3'h1 |=> zeroFlag == ($past(fileRdData) == 8'h00)
        && $stable(carryFlag)) else $error("move zero flag wrong");
    a_move_dest: assert property (
        tk && op == 3'h1 && instr.dest |=> fileWr.wrEn
        && fileWr.data == $past(fileRdData)) else $error("move write wrong");
    a_left_carry: assert property (
        tk && op == 3'h3 |=> carryFlag == $past(fileRdData[7])
        && $stable(zeroFlag)) else $error("left carry wrong");
    a_right_carry: assert property (
        tk && op == 3'h4 |=> carryFlag == $past(fileRdData[0])
        && $stable(zeroFlag)) else $error("right carry wrong");
    a_ret_pop: assert property (
        tk && (op == 3'h2 || op == 3'h5) |=> stackPop
        && pcOut == $past(stackTop)) else $error("return pop wrong");
    a_irq_enable: assert property (
        tk && op == 3'h2 |=> globalIrqEnable) else $error("irq enable low");
    a_lit_two: assert property (
        tk && op == 3'h5 |=> busy && wRegOut == $past(instr.literal)
        ##1 !busy && instrDone) else $error("literal return wrong");
    a_nop_step: assert property (
        tk && op == 3'h0 |=> instrDone && !fileWr.wrEn
        && pcOut == $past(pcOut) + 13'h1) else $error("idle step wrong");
endmodule
`default_nettype wire

// ==== bench/mrx_exec_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module mrx_exec_bench;
    logic                mclk = 1'b0;
    logic                rst = 1'b1;
    mrx_pkg::mrx_instr_s instr = '0;
    logic [7:0]          fileRdData = 8'h00;
    logic [12:0]         stackTop = 13'h0000;
    mrx_pkg::mrx_fwr_s   fileWr;
    logic [7:0]          wRegOut;
    logic [6:0]          fileRdAddr;
    logic [12:0]         pcOut;
    logic                stackPop, carryFlag, zeroFlag;
    logic                globalIrqEnable, busy, instrDone;
    int                  miscompares = 0;
    int                  n_tests = 0;
    mrx_exec dut_u (
        .mclk            (mclk),
        .rst             (rst),
        .instr           (instr),
        .fileRdData      (fileRdData),
        .stackTop        (stackTop),
        .fileRdAddr      (fileRdAddr),
        .fileWr          (fileWr),
        .stackPop        (stackPop),
        .wRegOut         (wRegOut),
        .pcOut           (pcOut),
        .carryFlag       (carryFlag),
        .zeroFlag        (zeroFlag),
        .globalIrqEnable (globalIrqEnable),
        .busy            (busy),
        .instrDone       (instrDone)
    );
    always #25 mclk = ~mclk;
    // wide enough for the flag plus the whole file-write struct
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // address fixed at the top of the range to cover the boundary
    task automatic go(input logic [2:0] o, input logic d,
                      input logic [7:0] rd, input logic [7:0] k,
                      input logic [12:0] s);
        @(posedge mclk);
        instr <= '{1'b1, mrx_pkg::mrx_op_e'(o), 7'h7F, d, k};
        fileRdData <= rd;
        stackTop <= s;
        @(posedge mclk);
        instr.valid <= 1'b0;
        #1;
    endtask
    task automatic summarize;
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_move;
        go(3'h1, 1'b0, 8'hA5, 8'h00, 13'h0);
        chk({zeroFlag, wRegOut}, 9'h0A5);
        chk(fileRdAddr, 7'h7F);
        go(3'h1, 1'b1, 8'h00, 8'h00, 13'h0);
        chk({zeroFlag, fileWr}, 17'h1FF00);
        $display("move test ended");
    endtask
    task automatic t_rotate;
        go(3'h3, 1'b0, 8'h81, 8'h00, 13'h0);
        chk({carryFlag, wRegOut}, 9'h102);
        go(3'h3, 1'b1, 8'h40, 8'h00, 13'h0);
        chk({carryFlag, fileWr.wrEn, fileWr.data}, 10'h181);
        go(3'h4, 1'b0, 8'h01, 8'h00, 13'h0);
        chk({carryFlag, wRegOut}, 9'h100);
        go(3'h4, 1'b1, 8'h02, 8'h00, 13'h0);
        chk({zeroFlag, carryFlag, fileWr.wrEn, fileWr.data}, 11'h581);
        $display("rotate test ended");
    endtask
    task automatic t_return;
        go(3'h5, 1'b0, 8'h00, 8'hFF, 13'h1ABC);
        chk({zeroFlag, carryFlag, busy, stackPop, wRegOut}, 12'hBFF);
        chk(pcOut, 13'h1ABC);
        @(posedge mclk);
        #1;
        chk({busy, instrDone}, 2'h1);
        go(3'h2, 1'b0, 8'h00, 8'h00, 13'h0123);
        chk({globalIrqEnable, pcOut}, 14'h2123);
        chk({zeroFlag, carryFlag, stackPop, busy}, 4'hB);
        $display("return test ended");
    endtask
    task automatic t_nop;
        logic [12:0] p;
        @(posedge mclk);
        #1;
        p = pcOut;
        go(3'h0, 1'b0, 8'h00, 8'h00, 13'h0);
        chk({instrDone, pcOut}, {1'b1, p + 13'h1});
        $display("idle test ended");
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        t_move();
        t_rotate();
        t_return();
        t_nop();
        summarize();
    end
    initial begin
        #20000;
        miscompares++;
        summarize();
    end
endmodule
bind mrx_exec mrx_exec_asserts u_chk (.*);
`default_nettype wire
